// File: logic/uic_regs.vh
`ifndef UIC_REGS_VH
`define UIC_REGS_VH
// ==========================================
// register offsets (byte addresses)
`define UIC_OFF_CTRL 8'h00
`define UIC_OFF_PPR 8'h04
`define UIC_OFF_MIN 8'h08
`define UIC_OFF_MAX 8'h0C
`define UIC_OFF_FILT 8'h10
`define UIC_OFF_VALUE 8'h14
`define UIC_OFF_STAT 8'h18
// ==========================================
// control register fields
`define UIC_F_TYPE 5:0
`define UIC_F_POL 6
`define UIC_F_PULL 8:7
`define UIC_F_GLITCH 10:9
`define UIC_F_DEB 13:11
// filter register fields
`define UIC_F_FCONST 7:0
`define UIC_F_FTYPE 9:8
// ==========================================
// reset values
`define UIC_RST_CTRL 32'h00000100
`define UIC_RST_PPR 16'h0000
`define UIC_RST_MIN 32'h00000000
`define UIC_RST_MAX 32'hFFFFFFFF
`define UIC_RST_FILT 10'h001
// ==========================================
// input type codes
`define UIC_TY_OFF 6'h00
`define UIC_TY_V5 6'h0C
`define UIC_TY_V10 6'h0D
`define UIC_TY_I20 6'h14
`define UIC_TY_I420 6'h15
`define UIC_TY_F0 6'h28
`define UIC_TY_F1 6'h29
`define UIC_TY_F2 6'h2A
`define UIC_TY_P0 6'h32
`define UIC_TY_P1 6'h33
`define UIC_TY_DN 6'h3C
`define UIC_TY_DI 6'h3D
`define UIC_TY_DL 6'h3E
// decoded type classes
`define UIC_CL_OFF 3'h0
`define UIC_CL_VOLT 3'h1
`define UIC_CL_CURR 3'h2
`define UIC_CL_FREQ 3'h3
`define UIC_CL_PWM 3'h4
`define UIC_CL_DNORM 3'h5
`define UIC_CL_DINV 3'h6
`define UIC_CL_DLAT 3'h7
// filter types and pull codes
`define UIC_FT_MOV 2'h1
`define UIC_FT_REP 2'h2
`define UIC_PULL_UP 2'h1
`define UIC_PULL_DOWN 2'h2
// ==========================================
// timing in 10 ns clock cycles, glitch lengths rounded up
`define UIC_GF1_CYC 12
`define UIC_GF2_CYC 178
`define UIC_GF3_CYC 1422
`define UIC_MS_CYC 100000
// debounce intervals in ms
`define UIC_DB1_MS 10
`define UIC_DB2_MS 20
`define UIC_DB3_MS 40
`define UIC_DB4_MS 100
`define UIC_DB5_MS 200
`define UIC_DB6_MS 400
`define UIC_DB7_MS 1000
`endif

// File: logic/uic_debounce.v
`timescale 1ns/1ps
// ==========================================
// level filter: accept a new level once stable for limit ticks
module uic_debounce #(
    parameter CW = 11
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire clr,
    input wire tick,
    input wire [CW-1:0] limit,
    // level in and out
    input wire din,
    output reg q
);
    reg [CW-1:0] cnt_reg; // ticks the new level has held

    // count while input differs, take it at the limit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {CW{1'b0}};
            q <= 1'b0;
        end else if (clr) begin
            cnt_reg <= {CW{1'b0}};
            q <= 1'b0;
        end else if (din == q) begin
            cnt_reg <= {CW{1'b0}}; // level restored, restart
        end else if (cnt_reg >= limit) begin
            q <= din; // limit zero passes at once
            cnt_reg <= {CW{1'b0}};
        end else if (tick) begin
            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule // uic_debounce

// File: logic/uic_avg.v
`timescale 1ns/1ps
`include "uic_regs.vh"
// ==========================================
// averaging filter: none, moving or repeating
module uic_avg #(
    parameter W = 32,
    parameter CW = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire clr,
    input wire [1:0] ftype,
    input wire [CW-1:0] fconst,
    // sample in
    input wire in_valid,
    input wire [W-1:0] in_data,
    // filtered out
    output reg out_valid,
    output reg [W-1:0] out_data
);
    reg [W+CW-1:0] sum_reg; // repeating sum
    reg [CW-1:0] cnt_reg; // readings summed so far
    // constant zero acts as one
    wire [CW-1:0] k = (fconst == {CW{1'b0}}) ?
        {{(CW-1){1'b0}}, 1'b1} : fconst;
    wire [W:0] diff = {1'b0, in_data} - {1'b0, out_data};
    wire signed [W:0] step = $signed(diff) / $signed({1'b0, k});
    wire [W+CW-1:0] acc = sum_reg + {{CW{1'b0}}, in_data};
    wire [W+CW-1:0] quot = acc / {{W{1'b0}}, k};

    // one update per accepted sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_reg <= {(W+CW){1'b0}};
            cnt_reg <= {CW{1'b0}};
            out_data <= {W{1'b0}};
            out_valid <= 1'b0;
        end else if (clr) begin
            sum_reg <= {(W+CW){1'b0}};
            cnt_reg <= {CW{1'b0}};
            out_data <= {W{1'b0}};
            out_valid <= 1'b0;
        end else begin
            out_valid <= 1'b0;
            if (in_valid) begin
                case (ftype)
                    `UIC_FT_MOV: begin
                        out_data <= out_data + step[W-1:0]; // RULE19
                        out_valid <= 1'b1;
                    end
                    `UIC_FT_REP: begin
                        if (cnt_reg == k - {{(CW-1){1'b0}}, 1'b1}) begin
                            out_data <= quot[W-1:0]; // RULE20
                            out_valid <= 1'b1;
                            sum_reg <= {(W+CW){1'b0}};
                            cnt_reg <= {CW{1'b0}};
                        end else begin
                            sum_reg <= acc; // RULE20
                            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
                        end
                    end
                    default: begin
                        out_data <= in_data; // RULE18
                        out_valid <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // uic_avg

// File: logic/uic_top.v
// ==========================================
// How it works
// RULE1 - decode type codes 0,12..62 into classes
// RULE2 - voltage and current take 12-bit converter
// RULE3 - frequency, pulse width use 16-bit capture
// RULE4 - glitch filter: none, 111ns, 1.78us, 14.22us
// RULE5 - debounce code picks 0 to 1000 ms
// RULE6 - nonzero pulses-per-rev multiplies measured value
// RULE7 - digital types report 1 or 0
// RULE8 - pull selector off/up/down, down by default
// RULE9 - polarity zero active high, default
// RULE10 - normal digital reports active level
// RULE11 - inverse digital reports inverted level
// RULE12 - latched toggles on inactive-to-active edge
// RULE13 - no fault diagnostics in digital types
// RULE14 - control value clamped to min/max
// RULE15 - range compared in current type's units
// RULE16 - selectable averaging, none by default
// RULE17 - fixed digital inputs are active low
// RULE18 - filter type none, moving, repeating
// RULE19 - moving average adds difference over constant
// RULE20 - repeating average sums N, divides, restarts
// RULE21 - debounce accepts level stable for interval
// RULE22 - reset or type change clears latch, filters
`timescale 1ns/1ps
`include "uic_regs.vh"
module uic_top #(
    parameter MS_CYCLES = `UIC_MS_CYC,
    parameter ADC_W = 12,
    parameter CAP_W = 16,
    parameter N_DIN = 3
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // universal input pin and converter
    input wire uin_pin,
    input wire [ADC_W-1:0] adc_data,
    input wire adc_valid,
    // fixed digital inputs, low is asserted
    input wire [N_DIN-1:0] din_n,
    // front-end control
    output reg pull_up_en,
    output reg pull_down_en,
    output reg adc_en,
    output reg cap_en,
    output reg fault_diag_en,
    // control source values
    output reg [31:0] ctrl_value,
    output reg ctrl_valid,
    output reg [N_DIN-1:0] din_state
);
    // ==========================================
    // functions
    // type code to class
    function [2:0] type_class;
        input [5:0] code;
        begin
            case (code)
                `UIC_TY_V5, `UIC_TY_V10: type_class = `UIC_CL_VOLT;
                `UIC_TY_I20, `UIC_TY_I420: type_class = `UIC_CL_CURR;
                `UIC_TY_F0, `UIC_TY_F1, `UIC_TY_F2:
                    type_class = `UIC_CL_FREQ;
                `UIC_TY_P0, `UIC_TY_P1: type_class = `UIC_CL_PWM;
                `UIC_TY_DN: type_class = `UIC_CL_DNORM;
                `UIC_TY_DI: type_class = `UIC_CL_DINV;
                `UIC_TY_DL: type_class = `UIC_CL_DLAT;
                default: type_class = `UIC_CL_OFF;
            endcase
        end
    endfunction

    // glitch selector to cycles
    function [10:0] glitch_lim;
        input [1:0] sel;
        reg [31:0] t;
        begin
            case (sel)
                2'h1: t = `UIC_GF1_CYC;
                2'h2: t = `UIC_GF2_CYC;
                2'h3: t = `UIC_GF3_CYC;
                default: t = 0;
            endcase
            glitch_lim = t[10:0];
        end
    endfunction

    // debounce code to milliseconds
    function [10:0] deb_ms;
        input [2:0] code;
        reg [31:0] t;
        begin
            case (code)
                3'h1: t = `UIC_DB1_MS;
                3'h2: t = `UIC_DB2_MS;
                3'h3: t = `UIC_DB3_MS;
                3'h4: t = `UIC_DB4_MS;
                3'h5: t = `UIC_DB5_MS;
                3'h6: t = `UIC_DB6_MS;
                3'h7: t = `UIC_DB7_MS;
                default: t = 0;
            endcase
            deb_ms = t[10:0];
        end
    endfunction

    // ==========================================
    // registers
    reg [31:0] ctrl_reg; // type, polarity, pull, filters
    reg [15:0] ppr_reg; // pulses per revolution
    reg [31:0] min_reg; // range minimum
    reg [31:0] max_reg; // range maximum
    reg [9:0] filt_reg; // filter type and constant
    reg [5:0] ty_reg; // type code of last cycle
    wire [2:0] cls = type_class(ctrl_reg[`UIC_F_TYPE]); // RULE1
    wire type_chg = (ctrl_reg[`UIC_F_TYPE] != ty_reg); // RULE22
    wire is_adc = (cls == `UIC_CL_VOLT) || (cls == `UIC_CL_CURR);
    wire is_cap = (cls == `UIC_CL_FREQ) || (cls == `UIC_CL_PWM);
    wire is_dig = (cls == `UIC_CL_DNORM) || (cls == `UIC_CL_DINV) ||
        (cls == `UIC_CL_DLAT);
    wire pol = ctrl_reg[`UIC_F_POL];
    wire apb_wr = psel && penable && pready && pwrite;
    reg [31:0] rd_next; // read data chosen at setup
    reg err_next; // unmapped address flag

    // ==========================================
    // apb: answer in first access cycle
    always @* begin
        err_next = 1'b0;
        case (paddr)
            `UIC_OFF_CTRL: rd_next = ctrl_reg;
            `UIC_OFF_PPR: rd_next = {16'h0000, ppr_reg};
            `UIC_OFF_MIN: rd_next = min_reg;
            `UIC_OFF_MAX: rd_next = max_reg;
            `UIC_OFF_FILT: rd_next = {22'h000000, filt_reg};
            `UIC_OFF_VALUE: rd_next = ctrl_value;
            `UIC_OFF_STAT: rd_next = {24'h000000, 1'b0, cls,
                1'b0, din_state};
            default: begin
                rd_next = 32'h00000000;
                err_next = 1'b1;
            end
        endcase
    end

    // handshake and read data registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && err_next;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h00000000 : rd_next;
            end
        end
    end

    // register writes on the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `UIC_RST_CTRL; // RULE8 RULE9
            ppr_reg <= `UIC_RST_PPR;
            min_reg <= `UIC_RST_MIN;
            max_reg <= `UIC_RST_MAX;
            filt_reg <= `UIC_RST_FILT; // RULE16
        end else if (apb_wr) begin
            case (paddr)
                `UIC_OFF_CTRL: ctrl_reg <= {18'h00000, pwdata[13:0]};
                `UIC_OFF_PPR: ppr_reg <= pwdata[15:0];
                `UIC_OFF_MIN: min_reg <= pwdata;
                `UIC_OFF_MAX: max_reg <= pwdata;
                `UIC_OFF_FILT: filt_reg <= pwdata[9:0];
                default: ctrl_reg <= ctrl_reg; // unmapped or read-only, no effect
            endcase
        end
    end

    // track type code so any change clears state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ty_reg <= `UIC_TY_OFF;
        end else begin
            ty_reg <= ctrl_reg[`UIC_F_TYPE];
        end
    end

    // ==========================================
    // millisecond enable pulse
    reg [31:0] ms_cnt_reg; // divider count
    reg ms_tick; // one-cycle pulse per ms
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg <= 32'h00000000;
            ms_tick <= 1'b0;
        end else if (ms_cnt_reg == MS_CYCLES - 1) begin
            ms_cnt_reg <= 32'h00000000;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
            ms_tick <= 1'b0;
        end
    end

    // ==========================================
    // capture glitch filter and digital debounce
    wire glitch_q; // pin after capture filter
    wire dact; // debounced active level
    uic_debounce #(.CW(11)) u_glitch (
        .pclk(pclk),
        .presetn(presetn),
        .clr(type_chg),
        .tick(1'b1),
        .limit(glitch_lim(ctrl_reg[`UIC_F_GLITCH])), // RULE4
        .din(uin_pin),
        .q(glitch_q)
    );
    uic_debounce #(.CW(11)) u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .clr(type_chg),
        .tick(ms_tick),
        .limit(deb_ms(ctrl_reg[`UIC_F_DEB])), // RULE5 RULE21
        .din(uin_pin ^ pol), // RULE9
        .q(dact)
    );

    // ==========================================
    // digital interpretation
    reg dact_d_reg; // previous debounced level
    reg latch_reg; // latched state
    reg dig_val; // reported digital value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dact_d_reg <= 1'b0;
            latch_reg <= 1'b0;
        end else if (type_chg) begin
            dact_d_reg <= dact;
            latch_reg <= 1'b0; // RULE22
        end else begin
            dact_d_reg <= dact;
            if (dact && !dact_d_reg) begin
                latch_reg <= ~latch_reg; // RULE12
            end
        end
    end

    // choose value by digital class
    always @* begin
        case (cls)
            `UIC_CL_DNORM: dig_val = dact; // RULE10
            `UIC_CL_DINV: dig_val = ~dact; // RULE11
            `UIC_CL_DLAT: dig_val = latch_reg; // RULE12
            default: dig_val = 1'b0;
        endcase
    end

    // ==========================================
    // capture timer: period or active width
    wire cap_lvl = glitch_q ^ pol; // active level at timer
    reg cap_lvl_d_reg; // previous timer level
    reg [CAP_W-1:0] cap_cnt_reg; // saturating count since edge
    reg armed_reg; // a start edge has been seen
    reg [CAP_W-1:0] cap_sample; // last measurement
    reg cap_stb; // measurement ready pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_lvl_d_reg <= 1'b0;
            cap_cnt_reg <= {CAP_W{1'b0}};
            armed_reg <= 1'b0;
            cap_sample <= {CAP_W{1'b0}};
            cap_stb <= 1'b0;
        end else if (type_chg || !is_cap) begin
            cap_lvl_d_reg <= cap_lvl;
            cap_cnt_reg <= {CAP_W{1'b0}};
            armed_reg <= 1'b0;
            cap_stb <= 1'b0;
        end else begin
            cap_lvl_d_reg <= cap_lvl;
            cap_stb <= 1'b0;
            if (~&cap_cnt_reg) begin
                cap_cnt_reg <= cap_cnt_reg + {{(CAP_W-1){1'b0}}, 1'b1};
            end
            if (cap_lvl && !cap_lvl_d_reg) begin
                cap_cnt_reg <= {CAP_W{1'b0}};
                armed_reg <= 1'b1;
                if (armed_reg && cls == `UIC_CL_FREQ) begin
                    cap_sample <= cap_cnt_reg; // RULE3
                    cap_stb <= 1'b1;
                end
            end else if (!cap_lvl && cap_lvl_d_reg && armed_reg &&
                    cls == `UIC_CL_PWM) begin
                cap_sample <= cap_cnt_reg; // RULE3
                cap_stb <= 1'b1;
            end
        end
    end

    // ==========================================
    // sample select and revolution scaling
    reg samp_valid; // new measured value
    reg [31:0] samp_data; // measured value, native units
    wire [47:0] scaled = samp_data * {16'h0000, ppr_reg};
    always @* begin
        samp_valid = 1'b0;
        samp_data = 32'h00000000;
        if (is_adc) begin
            samp_valid = adc_valid;
            samp_data = {{(32-ADC_W){1'b0}}, adc_data}; // RULE2
        end else if (is_cap) begin
            samp_valid = cap_stb;
            samp_data = {{(32-CAP_W){1'b0}}, cap_sample};
        end
    end
    wire [31:0] meas = (ppr_reg != 16'h0000) ?
        scaled[31:0] : samp_data; // RULE6

    // ==========================================
    // averaging filter on measured values
    wire avg_valid; // filtered value ready
    wire [31:0] avg_data; // filtered value
    uic_avg #(.W(32), .CW(8)) u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .clr(type_chg), // RULE22
        .ftype(filt_reg[`UIC_F_FTYPE]), // RULE16
        .fconst(filt_reg[`UIC_F_FCONST]),
        .in_valid(samp_valid),
        .in_data(meas),
        .out_valid(avg_valid),
        .out_data(avg_data)
    );

    // ==========================================
    // range clamp and control value output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_value <= 32'h00000000;
            ctrl_valid <= 1'b0;
        end else if (type_chg) begin
            ctrl_value <= 32'h00000000;
            ctrl_valid <= 1'b0;
        end else if (is_dig) begin
            ctrl_value <= {31'h00000000, dig_val}; // RULE7
            ctrl_valid <= 1'b1;
        end else if (avg_valid) begin
            ctrl_valid <= 1'b1;
            if (avg_data < min_reg) begin
                ctrl_value <= min_reg; // RULE14 RULE15
            end else if (avg_data > max_reg) begin
                ctrl_value <= max_reg; // RULE14 RULE15
            end else begin
                ctrl_value <= avg_data;
            end
        end else begin
            ctrl_valid <= 1'b0;
        end
    end

    // ==========================================
    // front-end control and fixed inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_up_en <= 1'b0;
            pull_down_en <= 1'b0;
            adc_en <= 1'b0;
            cap_en <= 1'b0;
            fault_diag_en <= 1'b0;
            din_state <= {N_DIN{1'b0}};
        end else begin
            pull_up_en <= (is_cap || is_dig) &&
                (ctrl_reg[`UIC_F_PULL] == `UIC_PULL_UP); // RULE8
            pull_down_en <= (is_cap || is_dig) &&
                (ctrl_reg[`UIC_F_PULL] == `UIC_PULL_DOWN); // RULE8
            adc_en <= is_adc;
            cap_en <= is_cap;
            fault_diag_en <= (is_adc || is_cap) && !is_dig; // RULE13
            din_state <= ~din_n; // RULE17
        end
    end
endmodule // uic_top

// File: dv/uic_sensor.sv
`timescale 1ns/1ps
// ==========================================
// far side: sensor pin, converter, switches
module uic_sensor (
    // clock
    input wire pclk,
    // pull enables from the block
    input wire pull_up_en,
    input wire pull_down_en,
    // bench stimulus
    input wire drv_en,
    input wire drv_lvl,
    input wire adc_go,
    input wire [11:0] adc_val,
    input wire [2:0] din_lvl,
    // pins toward the block
    output logic uin_pin,
    output logic [11:0] adc_data,
    output logic adc_valid,
    output logic [2:0] din_n
);
    logic tgl_reg = 1'b0; // floating pin pattern
    // floating pin with no pull wanders every cycle
    always @(posedge pclk) begin
        tgl_reg <= ~tgl_reg;
    end
    // released pin follows the enabled pull
    always @* begin
        uin_pin = drv_en ? drv_lvl : pull_up_en ? 1'b1 :
            pull_down_en ? 1'b0 : tgl_reg;
    end
    // one-cycle conversion strobe, data scrambled between
    always @(posedge pclk) begin
        adc_valid <= adc_go;
        adc_data <= adc_go ? adc_val : ~adc_data;
    end
    // closed switch pulls the line to ground
    assign din_n = ~din_lvl;
endmodule // uic_sensor

// File: dv/uic_top_chk.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module uic_top_chk #(
    parameter N_DIN = 3
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // fixed inputs
    input wire [N_DIN-1:0] din_n,
    input wire [N_DIN-1:0] din_state,
    // front end and value
    input wire pull_up_en,
    input wire pull_down_en,
    input wire adc_en,
    input wire cap_en,
    input wire fault_diag_en,
    input wire [31:0] ctrl_value,
    input wire ctrl_valid
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // apb setup cycle
    sequence s_setup;
        psel && !penable;
    endsequence
    // settled digital output
    sequence s_dig;
        (ctrl_valid && !adc_en && !cap_en)[*3];
    endsequence
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_din_follow: assert property (
        $past(presetn) |-> din_state == ~$past(din_n))
        else $error("fixed input state wrong");
    a_pull_excl: assert property (!(pull_up_en && pull_down_en))
        else $error("both pulls on");
    a_diag_meas: assert property (
        fault_diag_en == (adc_en || cap_en))
        else $error("diagnostics in wrong type");
    a_path_excl: assert property (!(adc_en && cap_en))
        else $error("converter and capture both on");
    a_dig_bit: assert property (
        s_dig |-> ctrl_value[31:1] == 31'h0)
        else $error("digital value not 0 or 1");
endmodule // uic_top_chk
bind uic_top uic_top_chk #(.N_DIN(N_DIN)) u_chk (.*);

// File: dv/test_universal_input_conditioning.sv
`timescale 1ns/1ps
module test_universal_input_conditioning;
    // ==========================================
    // signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, drv_en = 1'b0, drv_lvl = 1'b0, adc_go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat;
    logic [11:0] adc_val = 12'h000, adc_data;
    logic [2:0] din_lvl = 3'h0, din_n, din_state;
    logic [31:0] prdata, ctrl_value;
    logic rerr, pready, pslverr, uin_pin, adc_valid, pull_up_en;
    logic pull_down_en, adc_en, cap_en, fault_diag_en, ctrl_valid;
    int fails = 0, tests_run = 0, cyc = 0;
    logic [5:0] ty_code [13] = '{6'h00, 6'h0C, 6'h0D, 6'h14, 6'h15,
        6'h28, 6'h29, 6'h2A, 6'h32, 6'h33, 6'h3C, 6'h3D, 6'h3E};
    logic [2:0] ty_cls [13] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3,
        3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6, 3'h7};
    always #5 pclk = ~pclk;
    // ==========================================
    // block and far side, ms tick shortened to 10 cycles
    uic_top #(.MS_CYCLES(10)) DUT (.*);
    uic_sensor u_sens (.*);
    // ==========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one converter sample, optionally wait for the value
    task sample(input logic [11:0] v, input logic wt);
        @(posedge pclk);
        adc_go <= 1'b1;
        adc_val <= v;
        @(posedge pclk);
        adc_go <= 1'b0;
        if (wt) begin
            @(posedge pclk iff ctrl_valid === 1'b1);
        end else begin
            repeat (4) @(posedge pclk);
        end
    endtask
    // set the pin, wait, compare the digital value
    task dig(input logic e, input logic l, input int n, input logic x);
        @(posedge pclk);
        drv_en <= e;
        drv_lvl <= l;
        repeat (n) @(posedge pclk);
        chk(ctrl_value, {31'h0, x});
    endtask
    // ==========================================
    // scenarios
    task t_reset;
        apb(0, 8'h00, 0);
        chk(rdat, 32'h100);
        apb(0, 8'h0C, 0);
        chk(rdat, 32'hFFFFFFFF);
        apb(0, 8'h10, 0);
        chk(rdat, 32'h1);
        apb(0, 8'h1C, 0);
        chk({31'h0, rerr}, 32'h1);
    endtask
    task t_types;
        for (int i = 0; i < 13; i++) begin
            apb(1, 8'h00, {24'h1, 2'b0, ty_code[i]});
            apb(0, 8'h18, 0);
            chk(rdat & 32'h70, {25'h0, ty_cls[i], 4'h0});
            chk(adc_en, ty_cls[i] == 3'h1 || ty_cls[i] == 3'h2);
            chk(cap_en, ty_cls[i] == 3'h3 || ty_cls[i] == 3'h4);
            chk(fault_diag_en, adc_en || cap_en);
            if (ty_cls[i] >= 3'h3) begin
                chk(pull_down_en, 1);
            end
        end
    endtask
    task t_analog;
        apb(1, 8'h00, 32'h10C);
        sample(12'h123, 1);
        chk(ctrl_value, 32'h123);
        apb(1, 8'h04, 32'h3);
        sample(12'h123, 1);
        chk(ctrl_value, 32'h369);
        apb(1, 8'h0C, 32'h200);
        sample(12'h123, 1);
        chk(ctrl_value, 32'h200);
        apb(1, 8'h04, 32'h0);
        apb(1, 8'h08, 32'h50);
        sample(12'h010, 1);
        chk(ctrl_value, 32'h50);
        apb(1, 8'h08, 32'h0);
        apb(1, 8'h0C, 32'hFFFFFFFF);
        apb(1, 8'h10, 32'h104);
        apb(1, 8'h00, 32'h100);
        apb(1, 8'h00, 32'h10C);
        sample(12'h100, 1);
        chk(ctrl_value, 32'h40);
        sample(12'h100, 1);
        chk(ctrl_value, 32'h70);
        apb(1, 8'h10, 32'h202);
        apb(1, 8'h00, 32'h100);
        apb(1, 8'h00, 32'h10C);
        sample(12'h010, 0);
        sample(12'h030, 1);
        chk(ctrl_value, 32'h20);
        sample(12'h050, 0);
        sample(12'h070, 1);
        chk(ctrl_value, 32'h60);
        apb(1, 8'h10, 32'h1);
    endtask
    task t_digital;
        apb(1, 8'h00, 32'h13C);
        dig(0, 0, 6, 0);
        dig(1, 1, 6, 1);
        apb(1, 8'h00, 32'h13D);
        dig(0, 0, 6, 1);
        dig(1, 1, 6, 0);
        apb(1, 8'h00, 32'h0FC);
        dig(0, 0, 6, 0);
        chk(pull_up_en, 1);
        dig(1, 0, 6, 1);
        apb(1, 8'h00, 32'h13E);
        dig(1, 0, 6, 0);
        dig(1, 1, 6, 1);
        dig(1, 0, 6, 1);
        dig(1, 1, 6, 0);
        apb(1, 8'h00, 32'h93C);
        dig(1, 0, 120, 0);
        dig(1, 1, 50, 0);
        dig(1, 0, 120, 0);
        dig(1, 1, 80, 0);
        dig(1, 1, 50, 1);
    endtask
    task t_din;
        @(posedge pclk);
        din_lvl <= 3'h5;
        repeat (3) @(posedge pclk);
        chk(din_state, 3'h5);
    endtask
    // ==========================================
    // verdict and run control
    task end_sim;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim;
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_types;
        t_analog;
        t_digital;
        t_din;
        end_sim;
    end
endmodule // test_universal_input_conditioning
